// >>> bench/rdec_core_assertions.sv
// concurrent checks on the instruction decode block ports
module rdec_core_assertions
   import rdec_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        prescaler_to_timer,
   input wire logic [FA-1:0] file_addr_ff,
   input wire rdec_fwr_t   file_wr_ff,
   input wire logic [7:0]  working_ff,
   input wire rdec_flags_t flags_ff,
   input wire logic        prescaler_clear_ff,
   input wire logic        watchdog_clear_ff,
   input wire logic        standby_ff,
   input wire logic        cycle_end_ff
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ========================================
   // instruction pacing
   a_end_spacing: assert property (cycle_end_ff |=> !cycle_end_ff [*3])
      else $error("instruction end pulses closer than four clocks");
   a_w_commit: assert property ($changed(working_ff) |-> cycle_end_ff)
      else $error("working register moved off the commit slot");
   a_standby_still: assert property (standby_ff && $past(standby_ff) |-> !cycle_end_ff)
      else $error("instruction completed during standby");

   // ========================================
   // file writes and their side effects
   a_wr_pulse: assert property (file_wr_ff.en |=> !file_wr_ff.en)
      else $error("file write strobe longer than one clock");
   a_wr_slot: assert property (file_wr_ff.en |-> cycle_end_ff)
      else $error("file write outside the instruction end");
   a_wr_addr: assert property (file_wr_ff.en |-> file_wr_ff.addr == $past(file_addr_ff))
      else $error("file write address differs from decoded field");
   a_presc_cause: assert property (prescaler_clear_ff |->
      file_wr_ff.en && file_wr_ff.addr == ADDR_TIMER_ZERO)
      else $error("prescaler cleared without timer write");
   // the assignment level is the one seen at the commit edge
   a_presc_needed: assert property (
      file_wr_ff.en && file_wr_ff.addr == ADDR_TIMER_ZERO && $past(prescaler_to_timer)
      |-> prescaler_clear_ff)
      else $error("timer write left prescaler alone");

   // ========================================
   // status bits of standby and watchdog clear
   a_sleep_flags: assert property ($rose(standby_ff) |->
      flags_ff.timeout_status && !flags_ff.powerdown_status)
      else $error("standby entry flags wrong");
   a_wdt_flags: assert property (watchdog_clear_ff |->
      flags_ff.timeout_status && flags_ff.powerdown_status)
      else $error("watchdog clear flags wrong");
endmodule // rdec_core_assertions

bind rdec_core rdec_core_assertions u_rdec_core_assertions (.ref_clk, .rst_n,
   .prescaler_to_timer, .file_addr_ff, .file_wr_ff, .working_ff, .flags_ff,
   .prescaler_clear_ff, .watchdog_clear_ff, .standby_ff, .cycle_end_ff);

// >>> bench/rdec_core_tb.sv
// self-checking bench for the instruction decode block
module rdec_core_tb;
   import rdec_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic              ref_clk;
   logic              rst_n;
   logic [IW-1:0]     instr_word;
   logic [7:0]        file_rdata;
   logic [7:0]        port_b_pins;
   logic              prescaler_to_timer;
   logic              wake_event;
   logic [1:0]        pc_high_latch;
   logic [PW-1:0]     prog_addr_ff;
   logic [FA-1:0]     file_addr_ff;
   rdec_fwr_t         file_wr_ff;
   logic [7:0]        working_ff;
   rdec_flags_t       flags_ff;
   logic              prescaler_clear_ff;
   logic              watchdog_clear_ff;
   logic              int_enable_set_ff;
   logic              standby_ff;
   logic              cycle_end_ff;
   logic [2:0]        cdz;
   int                n_errors;
   int                n_checks;

   assign cdz = {flags_ff.carry, flags_ff.digit_carry_flag, flags_ff.zero};

   rdec_core u_rdec_core (.ref_clk, .rst_n, .instr_word, .file_rdata, .port_b_pins,
      .prescaler_to_timer, .wake_event, .pc_high_latch, .prog_addr_ff, .file_addr_ff,
      .file_wr_ff, .working_ff, .flags_ff, .prescaler_clear_ff, .watchdog_clear_ff,
      .int_enable_set_ff, .standby_ff, .cycle_end_ff);

   // ========================================
   // clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ========================================
   // helpers
   function automatic logic [IW-1:0] bw(input logic [3:0] op, input logic d,
                                        input logic [6:0] f);
      return {CLS_BYTE, op, d, f};
   endfunction

   function automatic logic [IW-1:0] lw(input logic [3:0] op, input logic [7:0] k);
      return {CLS_LIT, op, k};
   endfunction

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one instruction slot is four clocks, word held the whole slot
   task automatic ex(input logic [IW-1:0] w, input logic [7:0] fd = 8'h00);
      instr_word = w;
      file_rdata = fd;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask

   // write strobe and address stand for the clock after the commit
   task automatic wr_chk(input logic [6:0] a, input logic [7:0] d);
      chk("file write", {1'b1, a, d}, file_wr_ff);
      chk("file addr", {9'h000, a}, file_addr_ff);
   endtask

   task automatic sk(input logic [IW-1:0] w, input logic [7:0] fd, input logic skip);
      ex(lw(4'h0, 8'h99));
      ex(w, fd);
      ex(lw(4'h0, 8'h5a));
      chk("skip", skip ? 16'h0099 : 16'h005a, working_ff);
   endtask

   task automatic summarize();
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ========================================
   // scenarios
   task automatic t_literal();
      ex(lw(4'h0, 8'h10));
      chk("cycle end", 16'h0001, cycle_end_ff);
      ex(lw(4'he, 8'h15));
      chk("addlit", 16'h0025, working_ff);
      chk("addlit flags", 3'b000, cdz);
      ex(lw(4'h0, 8'hf8));
      ex(lw(4'hf, 8'h08));
      chk("addlit wrap", 16'h0000, working_ff);
      chk("addlit wrap flags", 3'b111, cdz);
      ex(lw(LOP_OR, 8'h0f));
      chk("orlit flags", {8'h0f, 3'b110}, {working_ff, cdz});
      ex(lw(LOP_XOR, 8'h0f));
      chk("xorlit flags", {8'h00, 3'b111}, {working_ff, cdz});
      ex(lw(4'h0, 8'h02));
      ex(lw(4'hc, 8'h05));
      chk("sublit", {8'h03, 3'b110}, {working_ff, cdz});
      ex(lw(4'hd, 8'h02));
      chk("sublit borrow", {8'hff, 3'b000}, {working_ff, cdz});
   endtask

   task automatic t_byte();
      ex(lw(4'h0, 8'h25));
      ex(bw(OP_ADD_W, 1'b0, 7'h20), 8'h10);
      chk("addf to w", {8'h35, 3'b000}, {working_ff, cdz});
      ex(bw(OP_ADD_W, 1'b1, 7'h7f), 8'h10);
      chk("addf keeps w", 16'h0035, working_ff);
      wr_chk(7'h7f, 8'h45);
      ex(bw(OP_OR_W, 1'b0, 7'h21), 8'h0a);
      chk("orf", {8'h3f, 3'b000}, {working_ff, cdz});
      ex(bw(OP_XOR_W, 1'b0, 7'h21), 8'h3f);
      chk("xorf", {8'h00, 3'b001}, {working_ff, cdz});
      ex(bw(OP_ROT_LEFT, 1'b0, 7'h21), 8'h81);
      chk("rotl", {8'h02, 3'b101}, {working_ff, cdz});
      ex(bw(OP_ROT_RIGHT, 1'b0, 7'h21), 8'h02);
      chk("rotr", {8'h81, 3'b001}, {working_ff, cdz});
      port_b_pins = 8'ha5;
      ex(bw(OP_MOVE_FILE, 1'b0, ADDR_PORT_B), 8'h00);
      chk("port read", 16'h00a5, working_ff);
      ex(bw(OP_COMPLEMENT, 1'b1, ADDR_PORT_B), 8'hff);
      wr_chk(ADDR_PORT_B, 8'h5a);
      ex({CLS_BIT, BOP_SET, 3'h3, 7'h24}, 8'h00);
      wr_chk(7'h24, 8'h08);
      ex({CLS_BIT, BOP_CLEAR, 3'h0, 7'h24}, 8'hff);
      wr_chk(7'h24, 8'hfe);
      ex(bw(OP_MOVE_W_TO_FILE, 1'b1, 7'h25));
      wr_chk(7'h25, 8'ha5);
   endtask

   task automatic t_skip();
      logic [2:0] f0;
      f0 = cdz;
      sk(bw(OP_DEC_SKIP, 1'b1, 7'h22), 8'h01, 1'b1);
      sk(bw(OP_DEC_SKIP, 1'b1, 7'h22), 8'h05, 1'b0);
      sk(bw(OP_INC_SKIP, 1'b1, 7'h22), 8'hff, 1'b1);
      sk(bw(OP_INC_SKIP, 1'b1, 7'h22), 8'h00, 1'b0);
      chk("skip flags", f0, cdz);
      sk({CLS_BIT, BOP_SKIP_CLR, 3'h7, 7'h23}, 8'h7f, 1'b1);
      sk({CLS_BIT, BOP_SKIP_CLR, 3'h7, 7'h23}, 8'hff, 1'b0);
      sk({CLS_BIT, BOP_SKIP_SET, 3'h0, 7'h23}, 8'h01, 1'b1);
      sk({CLS_BIT, BOP_SKIP_SET, 3'h0, 7'h23}, 8'hfe, 1'b0);
   endtask

   task automatic t_ctrl();
      pc_high_latch = 2'h1;
      ex(lw(4'h0, 8'h11));
      ex({CLS_JUMP, 1'b1, 11'h123});
      chk("jump target", 13'h0923, prog_addr_ff);
      ex(lw(4'h0, 8'h44));
      chk("jump flush", 16'h0011, working_ff);
      ex({CLS_JUMP, 1'b0, 11'h055});
      chk("call target", 13'h0855, prog_addr_ff);
      ex(14'h0000);
      ex(lw(4'h4, 8'h3c));
      ex(lw(4'h0, 8'h5a));
      chk("return literal", 16'h003c, working_ff);
      chk("return addr", 16'h0924, prog_addr_ff);
      ex({CLS_JUMP, 1'b0, 11'h066});
      ex(14'h0000);
      ex({6'h00, CW_INT_RET});
      chk("int return", {1'b1, 13'h0925}, {int_enable_set_ff, prog_addr_ff});
      ex(14'h0000);
      ex(14'h0100);
      chk("clear w", 16'h0000, working_ff);
   endtask

   task automatic t_timer();
      prescaler_to_timer = 1'b1;
      ex(bw(OP_CLEAR, 1'b1, ADDR_TIMER_ZERO));
      chk("presc clear", 16'h0001, prescaler_clear_ff);
      prescaler_to_timer = 1'b0;
      ex(bw(OP_CLEAR, 1'b1, ADDR_TIMER_ZERO));
      chk("presc kept", 16'h0000, prescaler_clear_ff);
   endtask

   // standby holds the first phase, so slots stay aligned after wake
   task automatic t_standby();
      ex({6'h00, CW_STANDBY});
      chk("standby", 3'b110,
          {standby_ff, flags_ff.timeout_status, flags_ff.powerdown_status});
      wake_event = 1'b1;
      for (int i = 0; i < 50 && standby_ff !== 1'b0; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
      chk("wake", 16'h0000, standby_ff);
      if (standby_ff !== 1'b0)
         summarize();
      wake_event = 1'b0;
      // powerdown is low after standby, so the clear is seen to act
      ex({6'h00, CW_WDT_CLEAR});
      chk("wdt flags", 3'b111, {watchdog_clear_ff, flags_ff.timeout_status,
          flags_ff.powerdown_status});
   endtask

   // ========================================
   // main sequence
   initial
   begin
      n_errors = 0;
      n_checks = 0;
      rst_n = 1'b0;
      instr_word = 14'h0000;
      file_rdata = 8'h00;
      port_b_pins = 8'h00;
      prescaler_to_timer = 1'b0;
      wake_event = 1'b0;
      pc_high_latch = 2'h0;
      repeat (12) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      chk("reset", {8'h00, 5'h03}, {working_ff, flags_ff});
      t_literal();
      t_byte();
      t_skip();
      t_ctrl();
      t_timer();
      t_standby();
      summarize();
   end

   // hang guard
   initial
   begin
      #200us;
      n_errors++;
      summarize();
   end
endmodule // rdec_core_tb

// >>> common/rdec_pkg.sv
// package for the 14-bit instruction decode and execute block
package rdec_pkg;
   // ========================================
   // widths
   localparam int unsigned IW = 14;
   localparam int unsigned FA = 7;
   localparam int unsigned PW = 13;
   localparam int unsigned JW = 11;
   localparam int unsigned SD = 8;
   localparam logic [2:0]  SP_TOP = 3'h7;
   // ========================================
   // timing: oscillator periods per instruction cycle
   localparam logic [1:0]  OSC_PER_CYCLE_M1 = 2'h3;
   // ========================================
   // class prefixes, bits 13:12
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT  = 2'h1;
   localparam logic [1:0] CLS_JUMP = 2'h2;
   localparam logic [1:0] CLS_LIT  = 2'h3;
   // byte class nibbles, bits 11:8
   localparam logic [3:0] OP_MOVE_W_TO_FILE   = 4'h0;
   localparam logic [3:0] OP_CLEAR            = 4'h1;
   localparam logic [3:0] OP_SUB_W_FROM_FILE  = 4'h2;
   localparam logic [3:0] OP_DECREMENT        = 4'h3;
   localparam logic [3:0] OP_OR_W             = 4'h4;
   localparam logic [3:0] OP_AND_W            = 4'h5;
   localparam logic [3:0] OP_XOR_W            = 4'h6;
   localparam logic [3:0] OP_ADD_W            = 4'h7;
   localparam logic [3:0] OP_MOVE_FILE        = 4'h8;
   localparam logic [3:0] OP_COMPLEMENT       = 4'h9;
   localparam logic [3:0] OP_INCREMENT        = 4'ha;
   localparam logic [3:0] OP_DEC_SKIP         = 4'hb;
   localparam logic [3:0] OP_ROT_RIGHT        = 4'hc;
   localparam logic [3:0] OP_ROT_LEFT         = 4'hd;
   localparam logic [3:0] OP_SWAP             = 4'he;
   localparam logic [3:0] OP_INC_SKIP         = 4'hf;
   // bit class, bits 11:10
   localparam logic [1:0] BOP_CLEAR     = 2'h0;
   localparam logic [1:0] BOP_SET       = 2'h1;
   localparam logic [1:0] BOP_SKIP_CLR  = 2'h2;
   localparam logic [1:0] BOP_SKIP_SET  = 2'h3;
   // literal class, bits 11:8 (x bits masked in decode)
   localparam logic [3:0] LOP_OR  = 4'h8;
   localparam logic [3:0] LOP_AND = 4'h9;
   localparam logic [3:0] LOP_XOR = 4'ha;
   // control words with class 00 nibble 0000, low byte
   localparam logic [7:0] CW_RETURN    = 8'h08;
   localparam logic [7:0] CW_INT_RET   = 8'h09;
   localparam logic [7:0] CW_STANDBY   = 8'h63;
   localparam logic [7:0] CW_WDT_CLEAR = 8'h64;
   // ========================================
   // special file addresses
   localparam logic [FA-1:0] ADDR_TIMER_ZERO = 7'h01;
   localparam logic [FA-1:0] ADDR_STATUS     = 7'h03;
   localparam logic [FA-1:0] ADDR_PORT_B     = 7'h06;
   // reset values
   localparam logic [7:0]    W_RESET  = 8'h00;
   localparam logic [PW-1:0] PC_RESET = 13'h0000;

   // ========================================
   // sequencer states, gray along q1..q4
   typedef enum logic [1:0]
   {
      RDEC_Q1 = 2'b00,
      RDEC_Q2 = 2'b01,
      RDEC_Q3 = 2'b11,
      RDEC_Q4 = 2'b10
   } rdec_q_t;

   // file register write request
   typedef struct packed
   {
      logic          en;
      logic [FA-1:0] addr;
      logic [7:0]    data;
   } rdec_fwr_t;

   // status flag group
   typedef struct packed
   {
      logic carry;
      logic digit_carry_flag;
      logic zero;
      logic timeout_status;
      logic powerdown_status;
   } rdec_flags_t;
endpackage : rdec_pkg

// >>> logic/rdec_core.sv
// instruction decode and execute for the 14-bit accumulator core
// Function
// (RQ1) destination bit picks working or file
// (RQ2) add literal to working, flags c dc z
// (RQ3) add working to file, flags c dc z
// (RQ4) decrement file, skip when zero
// (RQ5) increment file, skip when zero
// (RQ6) or working with file, zero only
// (RQ7) xor working with file, zero only
// (RQ8) rotate file left through carry
// (RQ9) rotate file right through carry
// (RQ10) skip next when tested bit clear
// (RQ11) skip next when tested bit set
// (RQ12) or literal into working, zero only
// (RQ13) xor literal into working, zero only
// (RQ14) literal minus working, flags c dc z
// (RQ15) load literal, return from stack, two cycles
// (RQ16) standby word sets standby, timeout, powerdown; the code clears powerdown instead
// (RQ17) port read-modify-write uses pin levels
// (RQ18) timer zero write clears assigned prescaler
// (RQ19) pc change or skip adds nop cycle
// (RQ20) one instruction cycle is four oscillator periods
// (RQ21) file address field is seven bits
// (RQ22) call pushes, jump loads eleven-bit target
// (RQ23) remaining words and bit clear set decoded
module rdec_core
   import rdec_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [IW-1:0]     instr_word,
   input  wire logic [7:0]        file_rdata,
   input  wire logic [7:0]        port_b_pins,
   input  wire logic              prescaler_to_timer,
   input  wire logic              wake_event,
   input  wire logic [1:0]        pc_high_latch,
   output logic [PW-1:0]          prog_addr_ff,
   output logic [FA-1:0]          file_addr_ff,
   output rdec_fwr_t              file_wr_ff,
   output logic [7:0]             working_ff,
   output rdec_flags_t            flags_ff,
   output logic                   prescaler_clear_ff,
   output logic                   watchdog_clear_ff,
   output logic                   int_enable_set_ff,
   output logic                   standby_ff,
   output logic                   cycle_end_ff
);
   // ========================================
   // q-phase sequencer
   rdec_q_t    q_ff;
   logic       nop_ff;
   logic [PW-1:0] pc_ff;
   logic [PW-1:0] stack_ff [SD];
   logic [2:0] sp_ff;
   logic [IW-1:0] ir_ff;

   // add with carry and digit carry: {c, dc, sum}
   function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      return {hi[4], lo[4], hi[3:0], lo[3:0]};
   endfunction

   // four oscillator periods per instruction cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q_ff <= RDEC_Q1;
      end
      else if (!standby_ff)
      begin
         // standby freezes the phase, so slots line up again after wake
         case (q_ff)
            RDEC_Q1: q_ff <= RDEC_Q2;
            RDEC_Q2: q_ff <= RDEC_Q3;
            RDEC_Q3: q_ff <= RDEC_Q4;
            RDEC_Q4: q_ff <= RDEC_Q1; // [RQ20]
            default: q_ff <= RDEC_Q1;
         endcase
      end
   end

   // ========================================
   // decode fields
   wire logic [1:0]    cls   = ir_ff[13:12];
   wire logic [3:0]    nib   = ir_ff[11:8];
   wire logic          dst   = ir_ff[7];
   wire logic [FA-1:0] faddr = ir_ff[FA-1:0]; // [RQ21]
   wire logic [2:0]    bsel  = ir_ff[9:7];
   wire logic [7:0]    lit   = ir_ff[7:0];

   // read-modify-write of the port takes the pin levels, not the latch
   wire logic [7:0] fval = (faddr == ADDR_PORT_B) ? port_b_pins : file_rdata; // [RQ17]

   logic [7:0]  res;
   logic        wr_file;
   logic        wr_w;
   logic        upd_z;
   logic        upd_cdc;
   logic        upd_c;
   logic        nc;
   logic        ndc;
   logic        skip;
   logic        jump;
   logic [PW-1:0] tgt;
   logic        push;
   logic        pop;
   logic        sleep_op;
   logic        wdt_op;
   logic        ie_op;
   logic [9:0]  sum;

   // execute combinationally in q3, committed at q4
   always_comb
   begin
      res = 8'h00; wr_file = 1'b0; wr_w = 1'b0; upd_z = 1'b0; upd_cdc = 1'b0;
      upd_c = 1'b0; nc = flags_ff.carry; ndc = flags_ff.digit_carry_flag;
      skip = 1'b0; jump = 1'b0; tgt = pc_ff; push = 1'b0; pop = 1'b0;
      sleep_op = 1'b0; wdt_op = 1'b0; ie_op = 1'b0; sum = 10'h000;
      case (cls)
         CLS_BYTE:
         begin
            wr_file = dst;  // [RQ1]
            wr_w    = !dst; // [RQ1]
            upd_z   = 1'b1;
            case (nib)
               OP_MOVE_W_TO_FILE:
               begin
                  upd_z = 1'b0;
                  wr_w  = 1'b0;
                  if (dst)
                     res = working_ff; // [RQ23]
                  else
                  begin
                     wr_file = 1'b0;
                     case (lit)
                        CW_RETURN:    begin pop = 1'b1; jump = 1'b1; end // [RQ23]
                        CW_INT_RET:   begin pop = 1'b1; jump = 1'b1; ie_op = 1'b1; end
                        CW_STANDBY:   sleep_op = 1'b1; // [RQ16]
                        CW_WDT_CLEAR: wdt_op = 1'b1;  // [RQ23]
                        default:      ;               // no-op
                     endcase
                  end
               end
               OP_CLEAR:           res = 8'h00; // [RQ23]
               OP_SUB_W_FROM_FILE:
               begin
                  sum = add8(fval, ~working_ff, 1'b1);
                  res = sum[7:0]; upd_cdc = 1'b1; nc = sum[9]; ndc = sum[8];
               end
               OP_DECREMENT:       res = fval - 8'h01;
               OP_OR_W:            res = working_ff | fval; // [RQ6]
               OP_AND_W:           res = working_ff & fval;
               OP_XOR_W:           res = working_ff ^ fval; // [RQ7]
               OP_ADD_W:
               begin
                  sum = add8(working_ff, fval, 1'b0); // [RQ3]
                  res = sum[7:0]; upd_cdc = 1'b1; nc = sum[9]; ndc = sum[8];
               end
               OP_MOVE_FILE:       res = fval;
               OP_COMPLEMENT:      res = ~fval;
               OP_INCREMENT:       res = fval + 8'h01;
               OP_DEC_SKIP:
               begin
                  res = fval - 8'h01; upd_z = 1'b0; skip = (res == 8'h00); // [RQ4]
               end
               OP_ROT_RIGHT:
               begin
                  res = {flags_ff.carry, fval[7:1]}; upd_z = 1'b0; upd_c = 1'b1; // [RQ9]
                  nc = fval[0];
               end
               OP_ROT_LEFT:
               begin
                  res = {fval[6:0], flags_ff.carry}; upd_z = 1'b0; upd_c = 1'b1; // [RQ8]
                  nc = fval[7];
               end
               OP_SWAP:            begin res = {fval[3:0], fval[7:4]}; upd_z = 1'b0; end
               OP_INC_SKIP:
               begin
                  res = fval + 8'h01; upd_z = 1'b0; skip = (res == 8'h00); // [RQ5]
               end
               default:            ;
            endcase
         end
         CLS_BIT:
         begin
            res = fval;
            case (ir_ff[11:10])
               BOP_CLEAR:    begin res[bsel] = 1'b0; wr_file = 1'b1; end // [RQ23]
               BOP_SET:      begin res[bsel] = 1'b1; wr_file = 1'b1; end // [RQ23]
               BOP_SKIP_CLR: skip = !fval[bsel]; // [RQ10]
               BOP_SKIP_SET: skip = fval[bsel];  // [RQ11]
               default:      ;
            endcase
         end
         CLS_JUMP:
         begin
            jump = 1'b1;
            push = !ir_ff[11]; // [RQ22]
            tgt  = {pc_high_latch, ir_ff[JW-1:0]}; // [RQ22]
         end
         default:
         begin
            wr_w = 1'b1;
            if (nib[3:2] == 2'b00)
               res = lit;
            else if (nib[3:2] == 2'b01)
            begin
               res = lit; pop = 1'b1; jump = 1'b1; // [RQ15]
            end
            else if (nib[3:1] == 3'b110)
            begin
               sum = add8(lit, ~working_ff, 1'b1); // [RQ14]
               res = sum[7:0]; upd_z = 1'b1; upd_cdc = 1'b1; nc = sum[9]; ndc = sum[8];
            end
            else if (nib[3:1] == 3'b111)
            begin
               sum = add8(working_ff, lit, 1'b0); // [RQ2]
               res = sum[7:0]; upd_z = 1'b1; upd_cdc = 1'b1; nc = sum[9]; ndc = sum[8];
            end
            else
            begin
               upd_z = 1'b1;
               case (nib)
                  LOP_OR:  res = working_ff | lit; // [RQ12]
                  LOP_AND: res = working_ff & lit;
                  LOP_XOR: res = working_ff ^ lit; // [RQ13]
                  default: res = working_ff;
               endcase
            end
         end
      endcase
      if (pop)
         tgt = stack_ff[sp_ff];
   end

   wire logic exec = (q_ff == RDEC_Q4) && !nop_ff && !standby_ff;

   // fetch latch at q1, program counter and stack at q4
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ir_ff <= 14'h0000; pc_ff <= PC_RESET; prog_addr_ff <= PC_RESET;
         sp_ff <= SP_TOP; nop_ff <= 1'b0;
         for (int i = 0; i < SD; i++)
            stack_ff[i] <= PC_RESET;
      end
      else if (q_ff == RDEC_Q1 && !standby_ff)
         ir_ff <= instr_word;
      else if (q_ff == RDEC_Q4 && !standby_ff)
      begin
         nop_ff <= exec && (jump || skip); // [RQ19]
         if (exec && jump)
         begin
            pc_ff <= tgt - 13'h0001; // nop slot steps onto the target, which is fetched next
            prog_addr_ff <= tgt;
         end
         else
         begin
            pc_ff <= pc_ff + 13'h0001;
            prog_addr_ff <= pc_ff + 13'h0001;
         end
         if (exec && push)
         begin
            sp_ff <= sp_ff + 3'h1;
            stack_ff[3'(sp_ff + 3'h1)] <= pc_ff + 13'h0001; // [RQ22] return address
         end
         else if (exec && pop)
            sp_ff <= sp_ff - 3'h1; // [RQ15]
      end
   end

   // working register, file write and side strobes
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         working_ff <= W_RESET; file_wr_ff <= '0; file_addr_ff <= '0;
         prescaler_clear_ff <= 1'b0; watchdog_clear_ff <= 1'b0;
         int_enable_set_ff <= 1'b0; cycle_end_ff <= 1'b0;
      end
      else
      begin
         file_addr_ff <= faddr;
         file_wr_ff.en <= exec && wr_file;
         file_wr_ff.addr <= faddr;
         file_wr_ff.data <= res;
         if (exec && wr_w)
            working_ff <= res; // [RQ1]
         prescaler_clear_ff <= exec && wr_file && faddr == ADDR_TIMER_ZERO
                               && prescaler_to_timer; // [RQ18]
         watchdog_clear_ff <= exec && wdt_op;
         int_enable_set_ff <= exec && ie_op;
         cycle_end_ff <= (q_ff == RDEC_Q4) && !standby_ff;
      end
   end

   // status flags; timeout and powerdown come up set
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags_ff <= '0; flags_ff.timeout_status <= 1'b1;
         flags_ff.powerdown_status <= 1'b1; standby_ff <= 1'b0;
      end
      else
      begin
         if (exec)
         begin
            if (upd_z)
               flags_ff.zero <= (res == 8'h00);
            if (upd_cdc || upd_c)
               flags_ff.carry <= nc; // [RQ8] [RQ9]
            if (upd_cdc)
               flags_ff.digit_carry_flag <= ndc; // [RQ3]
            if (sleep_op)
            begin
               flags_ff.timeout_status <= 1'b1;   // [RQ16]
               flags_ff.powerdown_status <= 1'b0; // [RQ16]
            end
            if (wdt_op)
            begin
               flags_ff.timeout_status <= 1'b1;
               flags_ff.powerdown_status <= 1'b1;
            end
         end
         if (exec && sleep_op)
            standby_ff <= 1'b1; // [RQ16]
         else if (wake_event)
            standby_ff <= 1'b0;
      end
   end
endmodule // rdec_core
